//--- crv_chip_reset_value_distribution.sv
`timescale 1ns/100ps
`default_nettype none
module crv_chip_reset_value_distribution
    import crv_pkg::*;
#(
    parameter int MAP_SIZE = 1024,
    parameter logic [7:0] REVISION = 8'h5A // Arbitrary value
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_host_hard_reset_pin_n,
    input wire logic i_host_cmd_wr,
    input wire logic [7:0] i_host_cmd_data,
    input wire logic i_host_devctl_wr,
    input wire logic [7:0] i_host_devctl_data,
    input wire logic [CRV_ADDR_W-1:0] i_up_addr,
    input wire logic i_up_wr,
    input wire logic [7:0] i_up_wdata,
    input wire logic [7:0] i_chip_status,
    output logic [7:0] o_up_rdata,
    output logic [7:0] o_host_status,
    output logic [7:0] o_host_error,
    output logic [7:0] o_host_command,
    output logic o_buffer_block_reset,
    output logic o_disk_block_reset,
    output logic o_host_block_reset,
    output logic o_host_soft_reset,
    output logic o_host_hard_reset
);
    // Map must cover every decoded offset and fit the address
    if (MAP_SIZE <= int'(TF_DEVICE_CONTROL_OFS) || MAP_SIZE > (1 << CRV_ADDR_W)) begin : g_chk
        $error("MAP_SIZE out of range");
    end

    logic [7:0] regs_w [MAP_SIZE];
    logic hard_meta_q;
    logic hard_sync_q;
    logic [7:0] up_rdata_q;
    logic [7:0] host_cmd_q;
    logic [7:0] src_now;
    logic diag_now;

    // Two-stage synchroniser for the host hard reset pin
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            hard_meta_q <= 1'b0;
            hard_sync_q <= 1'b0;
        end else begin
            hard_meta_q <= ~i_host_hard_reset_pin_n; // [R20]
            hard_sync_q <= hard_meta_q; // [R20]
        end
    end

    // Active reset sources this cycle; power-on acts through the async reset
    assign diag_now = i_host_cmd_wr && (i_host_cmd_data == DIAGNOSTIC_OPCODE);
    assign src_now = (hard_sync_q ? S_H : 8'h00) // [R1]
        | (regs_w[TF_DEVICE_CONTROL_OFS][HOST_SOFT_RESET_BIT] ? S_S : 8'h00) // [R1] [R19]
        | (regs_w[CHIP_RESET_POWERDOWN_CTL_OFS][BUFFER_BLOCK_RESET_BIT] ? S_F : 8'h00) // [R2]
        | (regs_w[CHIP_RESET_POWERDOWN_CTL_OFS][DISK_BLOCK_RESET_BIT] ? S_D : 8'h00) // [R2]
        | (regs_w[CHIP_RESET_POWERDOWN_CTL_OFS][HOST_BLOCK_RESET_BIT] ? S_B : 8'h00) // [R2]
        | (i_host_cmd_wr ? S_C : 8'h00)
        | (diag_now ? S_G : 8'h00);

    // One byte register per offset; reset patterns override writes
    for (genvar g = 0; g < MAP_SIZE; g++) begin : g_byte
        localparam logic [CRV_ADDR_W-1:0] IDX = CRV_ADDR_W'(g);
        localparam logic [7:0] POR_VAL = crv_apply(IDX, 8'h00, S_P);
        logic [7:0] q;
        wire logic host_hit = i_host_devctl_wr && (IDX == TF_DEVICE_CONTROL_OFS);
        wire logic up_hit = i_up_wr && (i_up_addr == IDX);
        wire logic [7:0] base = host_hit ? i_host_devctl_data : (up_hit ? i_up_wdata : q);
        always_ff @(posedge i_sys_clk or posedge i_reset) begin
            if (i_reset) begin
                q <= POR_VAL; // [R3] [R18]
            end else begin
                q <= crv_apply(IDX, base, src_now); // [R17] [R18]
            end
        end
        assign regs_w[g] = q;
    end

    // Registered read port and host command capture
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            up_rdata_q <= 8'h00;
            host_cmd_q <= 8'h00;
        end else begin
            if (i_up_addr == CHIP_STATUS_OFS) begin
                up_rdata_q <= i_chip_status; // [R3]
            end else if (i_up_addr == CHIP_REVISION_OFS) begin
                up_rdata_q <= REVISION; // [R3]
            end else if (int'(i_up_addr) < MAP_SIZE) begin
                up_rdata_q <= regs_w[i_up_addr];
            end else begin
                up_rdata_q <= 8'h00;
            end
            if (i_host_cmd_wr) begin
                host_cmd_q <= i_host_cmd_data;
            end
        end
    end

    assign o_up_rdata = up_rdata_q;
    assign o_host_command = host_cmd_q;
    assign o_host_status = regs_w[TF_STATUS_OFS]; // [R9]
    assign o_host_error = regs_w[TF_ERROR_OFS]; // [R10]
    assign o_buffer_block_reset = regs_w[CHIP_RESET_POWERDOWN_CTL_OFS][BUFFER_BLOCK_RESET_BIT];
    assign o_disk_block_reset = regs_w[CHIP_RESET_POWERDOWN_CTL_OFS][DISK_BLOCK_RESET_BIT];
    assign o_host_block_reset = regs_w[CHIP_RESET_POWERDOWN_CTL_OFS][HOST_BLOCK_RESET_BIT];
    assign o_host_soft_reset = regs_w[TF_DEVICE_CONTROL_OFS][HOST_SOFT_RESET_BIT];
    assign o_host_hard_reset = hard_sync_q;
endmodule
`default_nettype wire

//--- crv_chip_reset_value_distribution_sva.sv
`timescale 1ns/100ps
`default_nettype none
module crv_chip_reset_value_distribution_sva
    import crv_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h5A // Arbitrary value
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_host_hard_reset_pin_n,
    input wire logic i_host_cmd_wr,
    input wire logic [7:0] i_host_cmd_data,
    input wire logic i_host_devctl_wr,
    input wire logic [7:0] i_host_devctl_data,
    input wire logic [CRV_ADDR_W-1:0] i_up_addr,
    input wire logic i_up_wr,
    input wire logic [7:0] i_up_wdata,
    input wire logic [7:0] i_chip_status,
    input wire logic [7:0] o_up_rdata,
    input wire logic [7:0] o_host_status,
    input wire logic [7:0] o_host_error,
    input wire logic [7:0] o_host_command,
    input wire logic o_buffer_block_reset,
    input wire logic o_disk_block_reset,
    input wire logic o_host_block_reset,
    input wire logic o_host_soft_reset,
    input wire logic o_host_hard_reset
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // Local write to the block reset byte
    wire logic ctl_wr = i_up_wr && i_up_addr == CHIP_RESET_POWERDOWN_CTL_OFS;
    // Pin seen low, or high, on two edges running
    sequence pin_low2;
        !i_host_hard_reset_pin_n [*2];
    endsequence
    sequence pin_high2;
        i_host_hard_reset_pin_n [*2];
    endsequence
    por_blocks_a: assert property ($fell(i_reset) |-> o_host_block_reset &&
        o_disk_block_reset && o_buffer_block_reset)
        else $error("block resets not set after power-on");
    blk_hold_a: assert property (o_host_block_reset && !ctl_wr |=> o_host_block_reset)
        else $error("host block reset dropped without a write");
    blk_write_a: assert property (ctl_wr |=> {o_disk_block_reset, o_host_block_reset} ==
        {$past(i_up_wdata[2]), $past(i_up_wdata[0])}) else $error("block reset bits wrong");
    soft_set_a: assert property (i_host_devctl_wr && !o_host_block_reset &&
        !o_host_hard_reset |=> o_host_soft_reset == $past(i_host_devctl_data[2]))
        else $error("soft bit wrong");
    soft_status_a: assert property (o_host_soft_reset && !i_host_cmd_wr |=>
        o_host_status[7] && (o_host_status & 8'h0D) == 8'h00)
        else $error("status wrong under soft reset");
    cmd_clear_a: assert property (i_host_cmd_wr |=>
        o_host_command == $past(i_host_cmd_data)
        && (o_host_status & 8'h8D) == 8'h00 && o_host_error == 8'h00)
        else $error("command write did not clear status");
    hard_sync_a: assert property (pin_low2 |=> o_host_hard_reset)
        else $error("hard reset not seen two edges after pin");
    hard_idle_a: assert property (pin_high2 |=> !o_host_hard_reset)
        else $error("hard reset held after pin release");
    hard_status_a: assert property (o_host_hard_reset && !i_host_cmd_wr |=>
        (o_host_status & 8'hFD) == 8'h80) else $error("status wrong under hard reset");
    rev_read_a: assert property (i_up_addr == CHIP_REVISION_OFS |=> o_up_rdata == REVISION)
        else $error("revision read wrong");
    stat_read_a: assert property (i_up_addr == CHIP_STATUS_OFS |=>
        o_up_rdata == $past(i_chip_status)) else $error("chip status read wrong");
endmodule
bind crv_chip_reset_value_distribution crv_chip_reset_value_distribution_sva
    #(.REVISION(REVISION)) crv_sva_i (.*);
`default_nettype wire

//--- crv_chip_reset_value_distribution_test.sv
`timescale 1ns/100ps
`default_nettype none
module crv_chip_reset_value_distribution_test import crv_pkg::*;;
    typedef logic [25:0] crv_ent_t;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [9:0] i_up_addr = 10'h000;
    logic i_up_wr = 1'b0;
    logic [7:0] i_up_wdata = 8'h00;
    logic [7:0] i_chip_status = 8'h3C;
    int bad_count = 0;
    int num_checks = 0;
    wire logic pin_n, cmd_wr, dc_wr, bbr, dbr, hbr, host_soft_reset_bit, host_hard_reset_pin;
    wire logic [7:0] cmd_d, dc_d, rdata, stat, err, cmd_q;
    crv_host_model crv_host_model_i (.i_sys_clk(i_sys_clk), .o_pin_n(pin_n), .o_cmd_wr(cmd_wr),
        .o_cmd_data(cmd_d), .o_devctl_wr(dc_wr), .o_devctl_data(dc_d));
    crv_chip_reset_value_distribution crv_chip_reset_value_distribution_i (.i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_host_hard_reset_pin_n(pin_n), .i_host_cmd_wr(cmd_wr),
        .i_host_cmd_data(cmd_d), .i_host_devctl_wr(dc_wr), .i_host_devctl_data(dc_d),
        .i_up_addr(i_up_addr), .i_up_wr(i_up_wr), .i_up_wdata(i_up_wdata),
        .i_chip_status(i_chip_status), .o_up_rdata(rdata), .o_host_status(stat),
        .o_host_error(err), .o_host_command(cmd_q), .o_buffer_block_reset(bbr),
        .o_disk_block_reset(dbr), .o_host_block_reset(hbr), .o_host_soft_reset(host_soft_reset_bit),
        .o_host_hard_reset(host_hard_reset_pin));
    // Clock
    always #5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [7:0] e, input logic [7:0] g, input logic [9:0] a);
        num_checks++;
        if (g !== e) begin
            $display("wrong value reg %h expected %h seen %h", a, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_up_addr <= a;
        i_up_wr <= 1'b1;
        i_up_wdata <= d;
        @(posedge i_sys_clk);
        i_up_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_up_addr <= a;
        @(posedge i_sys_clk);
        #1 chk(e, rdata, a);
    endtask
    // Entries are address, written byte, expected byte
    task automatic wr_all(input crv_ent_t q[$]);
        foreach (q[i]) wr(q[i][25:16], q[i][15:8]);
    endtask
    task automatic rd_all(input crv_ent_t q[$]);
        foreach (q[i]) rd(q[i][25:16], q[i][7:0]);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Power-on defaults and block reset outputs right after release
    task automatic test_power_on();
        rd_all('{{10'h050, 8'h0, 8'h07}, {10'h051, 8'h0, 8'h00}, {10'h096, 8'h0, 8'h0F},
            {10'h098, 8'h0, 8'h18}, {10'h099, 8'h0, 8'h15}, {10'h09D, 8'h0, 8'hC0},
            {10'h0C5, 8'h0, 8'h98}, {10'h0D2, 8'h0, 8'h04}, {10'h0E0, 8'h0, 8'h40},
            {10'h200, 8'h0, 8'h40}, {10'h054, 8'h0, 8'h5A}, {10'h052, 8'h0, 8'h3C}});
        chk(8'h80, stat, TF_STATUS_OFS);
        chk(8'h07, {5'h00, dbr, bbr, hbr}, CHIP_RESET_POWERDOWN_CTL_OFS);
        $display("power-on test done");
    endtask
    // Block reset bits against bytes they reset and bytes they must leave alone
    task automatic test_block_reset();
        wr(10'h050, 8'h00);
        wr_all('{{10'h133, 8'hAA, 8'h0}, {10'h100, 8'h55, 8'h0}, {10'h130, 8'h33, 8'h0},
            {10'h097, 8'h11, 8'h0}, {10'h09D, 8'h11, 8'h0}, {10'h096, 8'h22, 8'h0},
            {10'h064, 8'hFF, 8'h0}, {10'h0C5, 8'h11, 8'h0}, {10'h0E0, 8'h11, 8'h0},
            {10'h3FF, 8'hA5, 8'h0}});
        wr(10'h050, 8'h07);
        #1 chk(8'h07, {5'h00, dbr, bbr, hbr}, CHIP_RESET_POWERDOWN_CTL_OFS);
        wr(10'h050, 8'h00);
        #1 chk(8'h00, {5'h00, dbr, bbr, hbr}, CHIP_RESET_POWERDOWN_CTL_OFS);
        rd_all('{{10'h133, 8'h0, 8'h00}, {10'h100, 8'h0, 8'h55}, {10'h130, 8'h0, 8'h33},
            {10'h097, 8'h0, 8'h00}, {10'h09D, 8'h0, 8'hC0}, {10'h096, 8'h0, 8'h22},
            {10'h064, 8'h0, 8'h9D}, {10'h0C5, 8'h0, 8'h98}, {10'h0E0, 8'h0, 8'h11},
            {10'h3FF, 8'h0, 8'hA5}});
        $display("block reset test done");
    endtask
    // Plain command write, then the diagnostic command
    task automatic test_command();
        wr_all('{{10'h0C8, 8'hFF, 8'h0}, {10'h0CA, 8'hFF, 8'h0}, {10'h0C1, 8'hFF, 8'h0},
            {10'h0A0, 8'hFF, 8'h0}, {10'h1F6, 8'hFF, 8'h0}, {10'h0A6, 8'hFF, 8'h0},
            {10'h1F7, 8'hFF, 8'h0}});
        crv_host_model_i.cmd(8'h20);
        rd_all('{{10'h0C8, 8'h0, 8'hFE}, {10'h0CA, 8'h0, 8'hF8}, {10'h0C1, 8'h0, 8'h1E},
            {10'h0A0, 8'h0, 8'h00}, {10'h1F6, 8'h0, 8'hFF}, {10'h0A6, 8'h0, 8'hFF},
            {10'h1F7, 8'h0, 8'h72}});
        chk(8'h20, cmd_q, TF_STATUS_OFS);
        wr_all('{{10'h0AC, 8'hFF, 8'h0}, {10'h0C1, 8'hFF, 8'h0}, {10'h0A0, 8'hFF, 8'h0},
            {10'h1F1, 8'hFF, 8'h0}});
        crv_host_model_i.cmd(8'h90);
        rd_all('{{10'h0AC, 8'h0, 8'h00}, {10'h0C1, 8'h0, 8'h0E}, {10'h1F6, 8'h0, 8'h00},
            {10'h0A6, 8'h0, 8'h00}, {10'h0A0, 8'h0, 8'h00}});
        chk(8'h00, err, TF_ERROR_OFS);
        $display("command test done");
    endtask
    // Soft reset held through the device control bit
    task automatic test_soft_reset();
        wr_all('{{10'h1F7, 8'hFF, 8'h0}, {10'h0C8, 8'hFF, 8'h0}, {10'h0E0, 8'hFF, 8'h0},
            {10'h0C5, 8'hFF, 8'h0}, {10'h0A0, 8'hFF, 8'h0}, {10'h0C1, 8'hFF, 8'h0},
            {10'h0AC, 8'hFF, 8'h0}, {10'h206, 8'hFF, 8'h0}, {10'h202, 8'hFF, 8'h0}});
        crv_host_model_i.devctl(8'h04);
        #1 chk(8'h01, {7'h00, host_soft_reset_bit}, TF_DEVICE_CONTROL_OFS);
        rd_all('{{10'h1F7, 8'h0, 8'hF2}, {10'h0C8, 8'h0, 8'h00}, {10'h0E0, 8'h0, 8'h40},
            {10'h0C5, 8'h0, 8'hFF}, {10'h0A0, 8'h0, 8'hFF}, {10'h0C1, 8'h0, 8'h8C},
            {10'h0AC, 8'h0, 8'hFF}, {10'h206, 8'h0, 8'h00}, {10'h202, 8'h0, 8'h02}});
        crv_host_model_i.devctl(8'h00);
        #1 chk(8'h00, {7'h00, host_soft_reset_bit}, TF_DEVICE_CONTROL_OFS);
        $display("soft reset test done");
    endtask
    // Hard reset pin pulse through the synchroniser
    task automatic test_hard_reset();
        wr_all('{{10'h0AC, 8'hFF, 8'h0}, {10'h1F6, 8'hFF, 8'h0}, {10'h0C5, 8'hFF, 8'h0},
            {10'h0E0, 8'hFF, 8'h0}, {10'h0A6, 8'hFF, 8'h0}, {10'h1F7, 8'hFF, 8'h0}});
        crv_host_model_i.hard(6);
        #1 chk(8'h01, {7'h00, host_hard_reset_pin}, TF_DEVICE_CONTROL_OFS);
        rd_all('{{10'h0AC, 8'h0, 8'h00}, {10'h1F6, 8'h0, 8'h00}, {10'h0C5, 8'h0, 8'hFF},
            {10'h0E0, 8'h0, 8'h40}, {10'h0A6, 8'h0, 8'h00}, {10'h1F7, 8'h0, 8'h82},
            {10'h050, 8'h0, 8'h00}});
        chk(8'h00, {7'h00, host_hard_reset_pin}, TF_DEVICE_CONTROL_OFS);
        $display("hard reset test done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        test_power_on();
        test_block_reset();
        test_command();
        test_soft_reset();
        test_hard_reset();
        stop_test();
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire

//--- crv_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module crv_host_model (
    input wire logic i_sys_clk,
    output logic o_pin_n,
    output logic o_cmd_wr,
    output logic [7:0] o_cmd_data,
    output logic o_devctl_wr,
    output logic [7:0] o_devctl_data
);
    // Idle host: pin released high, no strobes
    initial begin
        o_pin_n = 1'b1;
        o_cmd_wr = 1'b0;
        o_cmd_data = 8'h00;
        o_devctl_wr = 1'b0;
        o_devctl_data = 8'h00;
    end
    // Command write; data scrambled once the strobe drops
    task automatic cmd(input logic [7:0] d);
        @(posedge i_sys_clk);
        o_cmd_wr <= 1'b1;
        o_cmd_data <= d;
        @(posedge i_sys_clk);
        o_cmd_wr <= 1'b0;
        o_cmd_data <= ~d;
    endtask
    // Device control write; soft reset is bit 2
    task automatic devctl(input logic [7:0] d);
        @(posedge i_sys_clk);
        o_devctl_wr <= 1'b1;
        o_devctl_data <= d;
        @(posedge i_sys_clk);
        o_devctl_wr <= 1'b0;
        o_devctl_data <= ~d;
    endtask
    // Hard reset pin pulled low for n cycles
    task automatic hard(input int n);
        @(posedge i_sys_clk);
        o_pin_n <= 1'b0;
        repeat (n) @(posedge i_sys_clk);
        o_pin_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

//--- crv_pkg.sv
// Overview of operation
// [R1] Hard pin, soft bit, power-on reset act separately
// [R2] Control bits: 1 buffer, 2 disk, 0 host
// [R3] Chip control registers 050h-055h reset on power-on only
// [R4] Disk registers reset by power-on or disk bit
// [R5] Listed error-correction defaults, some also disk reset
// [R6] Host A0h, A6h, ACh clear on listed sources
// [R7] Interrupt status full or partial clear per source
// [R8] C1h takes three different patterns per source
// [R9] Task-file status patterns per reset source
// [R10] Error, drive/head, device control reset patterns
// [R11] Card status, pin, socket registers clear; code keeps bit 1 of 202h and 204h
// [R12] Buffer control bytes clear; pointers keep values
// [R13] Buffer 100h clears on power-on only
// [R14] E0h-E3h reset without host block reset
// [R15] Host config group resets on power-on or block
// [R16] BFh write side sets bits per source
// [R17] Unmarked registers and bits keep their value
// [R18] Block bits set at power-on, held till cleared
// [R19] Host sets soft reset via device control bit 2
// [R20] Hard reset pin synchronised before use
`default_nettype none
package crv_pkg;
    localparam int CRV_ADDR_W = 10;
    // Register offsets
    localparam logic [9:0] CHIP_RESET_POWERDOWN_CTL_OFS = 10'h050;
    localparam logic [9:0] CHIP_STATUS_OFS = 10'h052;
    localparam logic [9:0] CHIP_REVISION_OFS = 10'h054;
    localparam logic [9:0] TF_ERROR_OFS = 10'h1F1;
    localparam logic [9:0] TF_STATUS_OFS = 10'h1F7;
    localparam logic [9:0] TF_DEVICE_CONTROL_OFS = 10'h3F6;
    // Field positions
    localparam int HOST_BLOCK_RESET_BIT = 0;
    localparam int BUFFER_BLOCK_RESET_BIT = 1;
    localparam int DISK_BLOCK_RESET_BIT = 2;
    localparam int HOST_SOFT_RESET_BIT = 2;
    localparam logic [7:0] DIAGNOSTIC_OPCODE = 8'h90;
    // Reset sources, one bit each
    localparam logic [7:0] S_H = 8'h01;
    localparam logic [7:0] S_S = 8'h02;
    localparam logic [7:0] S_P = 8'h04;
    localparam logic [7:0] S_F = 8'h08;
    localparam logic [7:0] S_D = 8'h10;
    localparam logic [7:0] S_B = 8'h20;
    localparam logic [7:0] S_C = 8'h40;
    localparam logic [7:0] S_G = 8'h80;
    localparam logic [7:0] S_PD = S_P | S_D;
    localparam logic [7:0] S_PB = S_P | S_B;
    localparam logic [7:0] S_PF = S_P | S_F;
    localparam logic [7:0] S_HSP = S_H | S_S | S_P;
    localparam logic [7:0] S_HSPB = S_HSP | S_B;
    localparam logic [7:0] S_HPB = S_H | S_P | S_B;
    // Row: address range, sources, kept bits, bits forced to one
    typedef struct packed {
        logic [9:0] lo;
        logic [9:0] hi;
        logic [7:0] src;
        logic [7:0] keep;
        logic [7:0] set;
    } crv_row_t;
    localparam int CRV_NROW = 80;
    localparam crv_row_t CRV_ROWS [CRV_NROW] = '{
        '{10'h050, 10'h050, S_P, 8'h00, 8'h07}, // [R3] [R18]
        '{10'h051, 10'h055, S_P, 8'h00, 8'h00}, // [R3]
        '{10'h05D, 10'h05D, S_PD, 8'h40, 8'h00}, // [R4]
        '{10'h05E, 10'h05F, S_PD, 8'h64, 8'h00}, // [R4]
        '{10'h060, 10'h060, S_PD, 8'h10, 8'h00},
        '{10'h061, 10'h061, S_PD, 8'h00, 8'h00},
        '{10'h062, 10'h062, S_PD, 8'h20, 8'h00},
        '{10'h063, 10'h063, S_PD, 8'h08, 8'h00},
        '{10'h064, 10'h064, S_PD, 8'h99, 8'h04}, // [R4]
        '{10'h065, 10'h065, S_PD, 8'hF1, 8'h00},
        '{10'h066, 10'h067, S_PD, 8'h10, 8'h00},
        '{10'h073, 10'h073, S_PD, 8'h7F, 8'h00},
        '{10'h075, 10'h075, S_PD, 8'h3F, 8'h00},
        '{10'h07D, 10'h07D, S_PD, 8'h40, 8'h00},
        '{10'h07E, 10'h07E, S_PD, 8'h00, 8'h00},
        '{10'h085, 10'h085, S_PD, 8'h7F, 8'h00}, // [R4]
        '{10'h096, 10'h096, S_P, 8'h00, 8'h0F}, // [R5]
        '{10'h097, 10'h097, S_PD, 8'h00, 8'h00}, // [R5]
        '{10'h098, 10'h098, S_P, 8'h00, 8'h18}, // [R5]
        '{10'h099, 10'h099, S_P, 8'h00, 8'h15}, // [R5]
        '{10'h09A, 10'h09B, S_P, 8'h00, 8'h00}, // [R5]
        '{10'h09C, 10'h09C, S_PD, 8'h00, 8'h00}, // [R5]
        '{10'h09D, 10'h09D, S_PD, 8'h00, 8'hC0}, // [R5]
        '{10'h0A0, 10'h0A0, S_HPB | S_C, 8'h00, 8'h00}, // [R6]
        '{10'h0A6, 10'h0A6, S_HSPB | S_G, 8'h00, 8'h00}, // [R6]
        '{10'h0AC, 10'h0AC, S_H | S_G, 8'h00, 8'h00}, // [R6]
        '{10'h0B0, 10'h0B0, S_PB, 8'h00, 8'h00},
        '{10'h0B4, 10'h0B5, S_HPB, 8'hE0, 8'h00},
        '{10'h0BF, 10'h0BF, S_HSPB, 8'h9E, 8'h61}, // [R16]
        '{10'h0BF, 10'h0BF, S_G, 8'hBF, 8'h40}, // [R16]
        '{10'h0C0, 10'h0C0, S_PB, 8'h00, 8'h00},
        '{10'h0C1, 10'h0C1, S_HSPB, 8'h08, 8'h84}, // [R8]
        '{10'h0C1, 10'h0C1, S_S | S_G, 8'h0E, 8'h80}, // [R8]
        '{10'h0C1, 10'h0C1, S_C, 8'h1E, 8'h00}, // [R8]
        '{10'h0C2, 10'h0C3, S_PB, 8'h00, 8'h00}, // [R15]
        '{10'h0C4, 10'h0C4, S_PB, 8'h20, 8'h00}, // [R15]
        '{10'h0C5, 10'h0C5, S_PB, 8'h00, 8'h98}, // [R15]
        '{10'h0C6, 10'h0C6, S_PB, 8'h00, 8'h00}, // [R15]
        '{10'h0C8, 10'h0C8, S_HSPB, 8'h00, 8'h00}, // [R7]
        '{10'h0C8, 10'h0C8, S_C, 8'hFE, 8'h00}, // [R7]
        '{10'h0C9, 10'h0C9, S_PB, 8'h00, 8'h00}, // [R15]
        '{10'h0CA, 10'h0CA, S_HSPB, 8'hF0, 8'h00}, // [R7]
        '{10'h0CA, 10'h0CA, S_C, 8'hF8, 8'h00}, // [R7]
        '{10'h0CB, 10'h0CB, S_PB, 8'h00, 8'h00}, // [R15]
        '{10'h0CC, 10'h0CC, S_HSPB, 8'h00, 8'h00},
        '{10'h0CD, 10'h0CD, S_HSPB, 8'hBF, 8'h00},
        '{10'h0CE, 10'h0CE, S_HSPB | S_G, 8'h0E, 8'h40},
        '{10'h0CE, 10'h0CE, S_C, 8'h0E, 8'h40},
        '{10'h0CF, 10'h0CF, S_HSPB | S_C, 8'h00, 8'h00},
        '{10'h0D2, 10'h0D2, S_PB, 8'h00, 8'h04}, // [R15]
        '{10'h0E0, 10'h0E0, S_HSP, 8'h00, 8'h40}, // [R14]
        '{10'h0E1, 10'h0E2, S_HSP, 8'h02, 8'h00}, // [R14]
        '{10'h0E3, 10'h0E3, S_HSP, 8'h00, 8'h00}, // [R14]
        '{10'h0E4, 10'h0E5, S_PB, 8'hC0, 8'h00}, // [R15]
        '{10'h0E6, 10'h0E6, S_PB, 8'hFC, 8'h00}, // [R15]
        '{10'h100, 10'h100, S_P, 8'h00, 8'h00}, // [R13]
        '{10'h102, 10'h109, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h10B, 10'h10F, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h114, 10'h115, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h118, 10'h119, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h122, 10'h12B, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h12E, 10'h12F, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h133, 10'h133, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h137, 10'h137, S_PF, 8'h00, 8'h00},
        '{10'h13B, 10'h13B, S_PF, 8'h00, 8'h00},
        '{10'h13F, 10'h13F, S_PF, 8'h00, 8'h00},
        '{10'h143, 10'h143, S_PF, 8'h00, 8'h00},
        '{10'h147, 10'h147, S_PF, 8'h00, 8'h00},
        '{10'h14B, 10'h14B, S_PF, 8'h00, 8'h00},
        '{10'h14F, 10'h14F, S_PF, 8'h00, 8'h00}, // [R12]
        '{10'h1F1, 10'h1F1, S_C, 8'h00, 8'h00}, // [R10]
        '{10'h1F6, 10'h1F6, S_H | S_G, 8'h00, 8'h00}, // [R10]
        '{10'h1F7, 10'h1F7, S_HPB, 8'h02, 8'h80}, // [R9]
        '{10'h1F7, 10'h1F7, S_S, 8'h72, 8'h80}, // [R9]
        '{10'h1F7, 10'h1F7, S_C, 8'h72, 8'h00}, // [R9]
        '{10'h200, 10'h200, S_P, 8'h00, 8'h40},
        '{10'h202, 10'h202, S_HSP, 8'h02, 8'h00}, // [R11]
        '{10'h204, 10'h204, S_HSP, 8'h02, 8'h00}, // [R11]
        '{10'h206, 10'h206, S_HSPB, 8'h00, 8'h00}, // [R11]
        '{10'h3F6, 10'h3F6, S_HPB, 8'hF0, 8'h08} // [R10]
    };

    // Applies every matching row in table order; later rows win
    function automatic logic [7:0] crv_apply(input logic [9:0] a, input logic [7:0] v,
                                             input logic [7:0] s);
        logic [7:0] r;
        r = v;
        for (int i = 0; i < CRV_NROW; i++) begin
            if (a >= CRV_ROWS[i].lo && a <= CRV_ROWS[i].hi &&
                (s & CRV_ROWS[i].src) != 8'h00) begin
                r = (r & CRV_ROWS[i].keep) | CRV_ROWS[i].set; // [R1] [R17]
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire
